// *** design/spc_top.v ***
// Serial control port slave with the port configuration and feedback counter registers.
//
// Contract
// - Config register writes apply immediately, no update.
// - Short mode uses eight-bit instruction phase.
// - Reset leaves long instruction mode selected.
// - Restore bit defaults all registers except config.
// - Restore bit holds until zero written.
// - LSB first: shift low bit, address increments.
// - MSB first default: high bit, address decrements.
// - Output inactive: read data on bidirectional pin.
// - Swallow count six bits, upper two unused.
// - Main count thirteen bits across two registers.
`timescale 1ns/1ps
`include "spc_regs.vh"

module spc_top (
    input  wire                      clk_sys,
    input  wire                      sys_rst,
    input  wire                      sclk,
    input  wire                      cs_n,
    input  wire                      sdio_in,
    output reg                       sdio_out,
    output reg                       sdio_oe,
    output reg                       serial_output_pin,
    output reg                       serial_output_pin_oe,
    output reg  [7:0]                serial_port_config,
    output reg  [`SPC_SWALLOW_W-1:0] swallow_count,
    output reg  [`SPC_MAIN_W-1:0]    main_count
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Transaction states.

    localparam [1:0] ST_INSTR = 2'b00;
    localparam [1:0] ST_WRITE = 2'b01;
    localparam [1:0] ST_READ  = 2'b10;
    localparam [1:0] ST_DONE  = 2'b11;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection.

    wire                     sclk_s;
    wire                     cs_n_s;
    wire                     sdio_s;
    reg                      sclk_d;
    wire                     sclk_rise;
    wire                     sclk_fall;

    spc_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .pin_async (sclk),
        .pin_sync  (sclk_s)
    );

    spc_sync #(.RESET_VAL(1'b1)) u_sync_csn (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .pin_async (cs_n),
        .pin_sync  (cs_n_s)
    );

    spc_sync #(.RESET_VAL(1'b0)) u_sync_sdio (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .pin_async (sdio_in),
        .pin_sync  (sdio_s)
    );

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Transaction state and shift registers.

    reg  [1:0]               state;
    reg  [15:0]              instr;
    reg  [4:0]               instr_cnt;
    reg  [2:0]               bit_cnt;
    reg  [2:0]               out_cnt;
    reg  [7:0]               data_sr;
    reg  [7:0]               out_sr;
    reg  [`SPC_ADDR_W-1:0]   addr;
    reg  [1:0]               bytes_left;
    reg                      stream;
    reg                      rd_drive;
    reg                      pin_bit;
    reg                      wr_pulse;
    reg  [`SPC_ADDR_W-1:0]   wr_addr;
    reg  [7:0]               wr_data;

    wire                     long_mode;
    wire                     lsb_first;
    wire                     out_inactive;
    wire [4:0]               instr_len;
    wire [15:0]              next_instr;
    wire [7:0]               next_data;
    wire                     dec_rw;
    wire [1:0]               dec_w;
    wire [`SPC_ADDR_W-1:0]   dec_addr;
    wire [`SPC_ADDR_W-1:0]   next_addr;
    wire                     byte_last;
    reg  [7:0]               rd_data;
    wire [7:0]               out_byte;
    wire                     out_bit;

    assign long_mode    = serial_port_config[`SPC_CFG_LONG_BIT];
    assign lsb_first    = serial_port_config[`SPC_CFG_LSB_BIT];
    assign out_inactive = serial_port_config[`SPC_CFG_OUTINACT_BIT];

    // Instruction length follows the wide-instruction flag.
    assign instr_len = long_mode ? `SPC_INSTR_LONG_BITS : `SPC_INSTR_SHORT_BITS;

    // Bit order of the instruction and data shift follows the low-bit-first flag.
    assign next_instr = ~lsb_first ? {instr[14:0], sdio_s} :
                        long_mode  ? {sdio_s, instr[15:1]} :
                                     {8'h00, sdio_s, instr[7:1]};
    assign next_data  = lsb_first ? {sdio_s, data_sr[7:1]} :
                                    {data_sr[6:0], sdio_s};

    // Short instructions carry a five bit address.
    assign dec_rw   = long_mode ? next_instr[15]    : next_instr[7];
    assign dec_w    = long_mode ? next_instr[14:13] : next_instr[6:5];
    assign dec_addr = long_mode ? next_instr[12:0]  : {8'h00, next_instr[4:0]};

    // Multi-byte transfers step the address by bit order.
    assign next_addr = lsb_first ? addr + 13'h0001 : addr - 13'h0001;
    assign byte_last = ~stream && (bytes_left == 2'h0);

    // Read data for the current address; unused bits and slots read zero.
    always @* begin
        rd_data = 8'h00;
        case (addr)
            `SPC_OFF_CONFIG:    rd_data = serial_port_config;
            `SPC_OFF_SWALLOW:   rd_data = {2'b00, swallow_count};
            `SPC_OFF_MAIN_HIGH: rd_data = {3'b000, main_count[12:8]};
            `SPC_OFF_MAIN_LOW:  rd_data = main_count[7:0];
            default:            rd_data = 8'h00;
        endcase
    end

    assign out_byte = (out_cnt == 3'h0) ? rd_data : out_sr;
    assign out_bit  = lsb_first ? out_byte[0] : out_byte[7];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Transaction sequencer: sample on rising serial clock, drive on falling.

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state      <= ST_INSTR;
            instr      <= 16'h0000;
            instr_cnt  <= 5'h00;
            bit_cnt    <= 3'h0;
            out_cnt    <= 3'h0;
            data_sr    <= 8'h00;
            out_sr     <= 8'h00;
            addr       <= 13'h0000;
            bytes_left <= 2'h0;
            stream     <= 1'b0;
            rd_drive   <= 1'b0;
            pin_bit    <= 1'b0;
            wr_pulse   <= 1'b0;
            wr_addr    <= 13'h0000;
            wr_data    <= 8'h00;
        end else begin
            wr_pulse <= 1'b0;
            if (cs_n_s) begin
                state     <= ST_INSTR;
                instr     <= 16'h0000;
                instr_cnt <= 5'h00;
                bit_cnt   <= 3'h0;
                out_cnt   <= 3'h0;
                rd_drive  <= 1'b0;
            end else begin
                case (state)
                    ST_INSTR: begin
                        if (sclk_rise) begin
                            instr     <= next_instr;
                            instr_cnt <= instr_cnt + 5'h01;
                            if ((instr_cnt + 5'h01) == instr_len) begin
                                addr       <= dec_addr;
                                bytes_left <= dec_w;
                                stream     <= (dec_w == `SPC_STREAM_CODE);
                                bit_cnt    <= 3'h0;
                                out_cnt    <= 3'h0;
                                state      <= dec_rw ? ST_READ : ST_WRITE;
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (sclk_rise) begin
                            data_sr <= next_data;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == `SPC_LAST_DATA_BIT) begin
                                wr_pulse <= 1'b1;
                                wr_addr  <= addr;
                                wr_data  <= next_data;
                                addr     <= next_addr;
                                if (byte_last) begin
                                    state <= ST_DONE;
                                end else if (~stream) begin
                                    bytes_left <= bytes_left - 2'h1;
                                end
                            end
                        end
                    end
                    ST_READ: begin
                        if (sclk_fall) begin
                            rd_drive <= 1'b1;
                            pin_bit  <= out_bit;
                            out_sr   <= lsb_first ? {1'b0, out_byte[7:1]} :
                                                    {out_byte[6:0], 1'b0};
                            out_cnt  <= out_cnt + 3'h1;
                        end
                        if (sclk_rise) begin
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == `SPC_LAST_DATA_BIT) begin
                                addr <= next_addr;
                                if (byte_last) begin
                                    state <= ST_DONE;
                                end else if (~stream) begin
                                    bytes_left <= bytes_left - 2'h1;
                                end
                            end
                        end
                    end
                    ST_DONE: begin
                        state <= ST_DONE;
                    end
                    default: begin
                        state <= ST_INSTR;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            sdio_out             <= 1'b0;
            sdio_oe              <= 1'b0;
            serial_output_pin    <= 1'b0;
            serial_output_pin_oe <= 1'b0;
        end else begin
            sdio_out             <= pin_bit;
            serial_output_pin    <= pin_bit;
            sdio_oe              <= rd_drive & ~cs_n_s & out_inactive;
            serial_output_pin_oe <= rd_drive & ~cs_n_s & ~out_inactive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register file.

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            serial_port_config <= `SPC_CFG_RESET;
            swallow_count      <= `SPC_SWALLOW_RESET;
            main_count         <= `SPC_MAIN_RESET;
        end else begin
            if (wr_pulse) begin
                case (wr_addr)
                    `SPC_OFF_CONFIG: begin
                        // Takes effect on the next cycle with no update step.
                        serial_port_config <= wr_data & `SPC_CFG_WMASK;
                    end
                    `SPC_OFF_SWALLOW: begin
                        swallow_count <= wr_data[5:0];
                    end
                    `SPC_OFF_MAIN_HIGH: begin
                        main_count[12:8] <= wr_data[4:0];
                    end
                    `SPC_OFF_MAIN_LOW: begin
                        main_count[7:0] <= wr_data;
                    end
                    default: begin
                        main_count <= main_count;
                    end
                endcase
            end
            // Restore holds every other register at its default while set.
            if (serial_port_config[`SPC_CFG_RESTORE_BIT]) begin
                swallow_count <= `SPC_SWALLOW_RESET;
                main_count    <= `SPC_MAIN_RESET;
            end
        end
    end

endmodule

// *** design/spc_regs.vh ***
// Register offsets, field positions, reset values and framing counts of the serial port block.
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

`define SPC_ADDR_W            13
`define SPC_OFF_CONFIG        13'h0000
`define SPC_OFF_UNUSED_ONE    13'h0001
`define SPC_OFF_UNUSED_TWO    13'h0002
`define SPC_OFF_UNUSED_THREE  13'h0003
`define SPC_OFF_SWALLOW       13'h0004
`define SPC_OFF_MAIN_HIGH     13'h0005
`define SPC_OFF_MAIN_LOW      13'h0006

`define SPC_CFG_LONG_BIT      4
`define SPC_CFG_RESTORE_BIT   5
`define SPC_CFG_LSB_BIT       6
`define SPC_CFG_OUTINACT_BIT  7

`define SPC_CFG_WMASK         8'hf0
`define SPC_SWALLOW_W         6
`define SPC_MAIN_W            13
`define SPC_MAIN_HIGH_W       5

`define SPC_CFG_RESET         8'h10
`define SPC_SWALLOW_RESET     6'h00
`define SPC_MAIN_RESET        13'h0000

`define SPC_INSTR_LONG_BITS   5'h10
`define SPC_INSTR_SHORT_BITS  5'h08
`define SPC_LAST_DATA_BIT     3'h7
`define SPC_STREAM_CODE       2'h3

`endif

// *** design/spc_sync.v ***
// Two flip-flop synchroniser for one asynchronous pin.
`timescale 1ns/1ps

module spc_sync #(
    parameter RESET_VAL = 1'b0
) (
    input  wire clk_sys,
    input  wire sys_rst,
    input  wire pin_async,
    output reg  pin_sync
);

    reg stage_one;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            stage_one <= RESET_VAL;
            pin_sync  <= RESET_VAL;
        end else begin
            stage_one <= pin_async;
            pin_sync  <= stage_one;
        end
    end

endmodule

// *** verification/spc_assertions.sv ***
// Port checks for the serial port configuration and counter registers.
`timescale 1ns/1ps
module spc_assert_chk (
    input wire        clk_sys,
    input wire        sys_rst,
    input wire        sclk,
    input wire        cs_n,
    input wire        sdio_in,
    input wire        sdio_out,
    input wire        sdio_oe,
    input wire        serial_output_pin,
    input wire        serial_output_pin_oe,
    input wire [7:0]  serial_port_config,
    input wire [5:0]  swallow_count,
    input wire [12:0] main_count
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    reset_values_a: assert property (
        $fell(sys_rst) |-> serial_port_config == 8'h10 && swallow_count == 6'h00
        && main_count == 13'h0000) else $error("reset values wrong");
    cfg_quiet_a: assert property (
        cs_n [*4] |-> $stable(serial_port_config)) else $error("config moved idle");
    count_quiet_a: assert property (
        cs_n [*4] |-> $stable(swallow_count) && $stable(main_count))
        else $error("counts moved idle");
    restore_hold_a: assert property (
        serial_port_config[5] [*2] |-> swallow_count == 6'h00 && main_count == 13'h0000)
        else $error("restore not held");
    cfg_low_zero_a: assert property (
        serial_port_config[3:0] == 4'h0) else $error("unused config bits set");
    oe_exclusive_a: assert property (
        !(sdio_oe && serial_output_pin_oe)) else $error("both pins driven");
    bidir_mode_a: assert property (
        sdio_oe |-> serial_port_config[7]) else $error("data pin driven in wrong mode");
    ded_mode_a: assert property (
        serial_output_pin_oe |-> !serial_port_config[7]) else $error("output pin mode");
    idle_release_a: assert property (
        cs_n [*8] |-> !sdio_oe && !serial_output_pin_oe) else $error("pin driven idle");
    ////////////////////////////////////////
    bidir_read_c: cover property (sdio_oe);
    ded_read_c: cover property (serial_output_pin_oe);
    restore_c: cover property (serial_port_config[5]);
endmodule

bind spc_top spc_assert_chk chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk),
    .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_output_pin(serial_output_pin), .serial_output_pin_oe(serial_output_pin_oe),
    .serial_port_config(serial_port_config), .swallow_count(swallow_count),
    .main_count(main_count));

// *** verification/spc_host_model.sv ***
// Host controller model that frames serial port transfers.
`timescale 1ns/1ps
module spc_host_model (
    input  wire clk_sys,
    output reg  sclk,
    output reg  cs_n,
    output reg  sdio_in,
    input  wire sdio_out,
    input  wire sdio_oe,
    input  wire serial_output_pin,
    input  wire serial_output_pin_oe
);
    reg [1:0] oe_seen;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdio_in = 1'b0;
        oe_seen = 2'h0;
    end
    ////////////////////////////////////////
    task automatic half_wait;
        repeat (8) @(posedge clk_sys);
        #2;
    endtask
    task automatic clk_bit(input logic b, output logic r);
        sdio_in = b;
        half_wait;
        sclk = 1'b1;
        r = sdio_oe ? sdio_out : (serial_output_pin_oe ? serial_output_pin : 1'bx);
        oe_seen = {sdio_oe, serial_output_pin_oe};
        half_wait;
        sclk = 1'b0;
    endtask
    task automatic frame(input logic rw, input logic [1:0] w, input logic [12:0] a,
                         input logic lng, input logic lsb, input int nb,
                         input logic [23:0] wd, output logic [23:0] rdat);
        logic [15:0] ins;
        logic        r;
        int          i;
        int          j;
        int          n;
        ins = lng ? {rw, w, a} : {8'h00, rw, w, a[4:0]};
        n = lng ? 16 : 8;
        rdat = 24'h0;
        cs_n = 1'b0;
        half_wait;
        for (i = 0; i < n; i++) clk_bit(ins[lsb ? i : n-1-i], r);
        for (i = 0; i < 8*nb; i++) begin
            j = 8*(i/8) + (lsb ? i%8 : 7-i%8);
            clk_bit(rw ? ~sdio_in : wd[j], r);
            rdat[j] = r;
        end
        half_wait;
        cs_n = 1'b1;
        half_wait;
    endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the serial port configuration and counter registers.
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    wire         sclk, cs_n, sdio_in, sdio_out, sdio_oe, so_pin, so_oe;
    wire  [7:0]  cfg;
    wire  [5:0]  swc;
    wire  [12:0] mnc;
    int          n_fail = 0;
    int          checks_done = 0;
    logic        lng = 1'b1;
    logic        lsb = 1'b0;
    logic [23:0] rdat;
    always #12.5 clk_sys = ~clk_sys;
    spc_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .serial_output_pin(so_pin), .serial_output_pin_oe(so_oe),
        .serial_port_config(cfg), .swallow_count(swc), .main_count(mnc));
    spc_host_model host_u (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .serial_output_pin(so_pin), .serial_output_pin_oe(so_oe));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic regs(input logic [7:0] c, input logic [5:0] s, input logic [12:0] m);
        check({cfg, 2'h0, swc, 3'h0, mnc}, {c, 2'h0, s, 3'h0, m});
    endtask
    task automatic wr(input logic [12:0] a, input int nb, input logic [23:0] d);
        host_u.frame(1'b0, 2'(nb-1), a, lng, lsb, nb, d, rdat);
    endtask
    task automatic rd(input logic [12:0] a, input int nb, input logic [23:0] e);
        host_u.frame(1'b1, 2'(nb-1), a, lng, lsb, nb, 24'h0, rdat);
        check({8'h00, rdat}, {8'h00, e});
    endtask
    task automatic end_of_test;
        $display("checks %0d, failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #2000000;
        n_fail++;
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        #2 sys_rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        #2;
        regs(8'h10, 6'h00, 13'h0000);
        rd(13'h0000, 1, 24'h10);
        wr(13'h0004, 1, 24'hff);
        regs(8'h10, 6'h3f, 13'h0000);
        rd(13'h0004, 1, 24'h3f);
        wr(13'h0006, 3, 24'hc1f35a);
        regs(8'h10, 6'h01, 13'h135a);
        rd(13'h0006, 3, 24'h01135a);
        wr(13'h0002, 1, 24'hff);
        rd(13'h0002, 1, 24'h00);
        rd(13'h0009, 1, 24'h00);
        wr(13'h0000, 1, 24'h90);
        regs(8'h90, 6'h01, 13'h135a);
        rd(13'h0005, 1, 24'h13);
        check({30'h0, host_u.oe_seen}, 32'h2);
        wr(13'h0000, 1, 24'h00);
        lng = 1'b0;
        rd(13'h0005, 1, 24'h13);
        check({30'h0, host_u.oe_seen}, 32'h1);
        wr(13'h0004, 1, 24'h2b);
        regs(8'h00, 6'h2b, 13'h135a);
        wr(13'h0000, 1, 24'h40);
        lsb = 1'b1;
        wr(13'h0005, 2, 24'h770a);
        regs(8'h40, 6'h2b, 13'h0a77);
        rd(13'h0005, 2, 24'h770a);
        host_u.frame(1'b0, 2'h3, 13'h0005, lng, lsb, 2, 24'h1c05, rdat);
        regs(8'h40, 6'h2b, 13'h051c);
        host_u.frame(1'b1, 2'h3, 13'h0005, lng, lsb, 2, 24'h0, rdat);
        check({8'h00, rdat}, {8'h00, 24'h001c05});
        wr(13'h0000, 1, 24'h60);
        regs(8'h60, 6'h00, 13'h0000);
        wr(13'h0004, 1, 24'h11);
        regs(8'h60, 6'h00, 13'h0000);
        wr(13'h0000, 1, 24'h40);
        wr(13'h0004, 1, 24'h11);
        regs(8'h40, 6'h11, 13'h0000);
        wr(13'h0000, 1, 24'h50);
        lng = 1'b1;
        rd(13'h0004, 1, 24'h11);
        regs(8'h50, 6'h11, 13'h0000);
        sys_rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #2 sys_rst = 1'b0;
        repeat (2) @(posedge clk_sys);
        #2;
        regs(8'h10, 6'h00, 13'h0000);
        end_of_test;
    end
endmodule
